// file: common/bram_params.svh
// Purpose: Shared constants for the dual-port block RAM.
// Assumes: True dual-port build, ECC on, one ECC pipe stage and one output register per port.
// Notes: What this block does is listed below.
`ifndef BRAM_PARAMS_SVH
`define BRAM_PARAMS_SVH
`define BRAM_DATA_W      16
`define BRAM_DEPTH_A     256
`define BRAM_DEPTH_B     256
`define BRAM_ADDR_A_W    $clog2(`BRAM_DEPTH_A)
`define BRAM_ADDR_B_W    $clog2(`BRAM_DEPTH_B)
`define BRAM_BYTE_WRITE  0
`define BRAM_BYTE_SIZE   8
`define BRAM_WE_W        ((`BRAM_BYTE_WRITE != 0) ? (`BRAM_DATA_W / `BRAM_BYTE_SIZE) : 1)
`define BRAM_PAR_N       5
`define BRAM_CODE_W      (`BRAM_DATA_W + `BRAM_PAR_N + 1)
`define BRAM_CODE_TOP    (`BRAM_CODE_W - 1)
`define BRAM_OVERALL_BIT 0
`define BRAM_INJ_BIT0    3
`define BRAM_INJ_BIT1    5
`define BRAM_TRUE_DUAL   1
`endif

// file: common/bram_pkg.sv
// Purpose: Types shared by the block RAM files.
// Assumes: bram_params.svh supplies the widths.
// Notes: Port A and port B share one word width in this build.
`include "bram_params.svh"
package bram_pkg;
    typedef logic [`BRAM_DATA_W-1:0]   data_t;
    typedef logic [`BRAM_CODE_W-1:0]   code_t;
    typedef logic [`BRAM_ADDR_A_W-1:0] addr_a_t;
    typedef logic [`BRAM_ADDR_B_W-1:0] addr_b_t;
endpackage : bram_pkg

// file: design/dual_port_bram.sv
// Purpose: True dual-port ECC block RAM with native ports A and B.
// Assumes: Both ports are driven from logic on clk_i, so no input is synchronised.
// Notes: Same-address writes from both ports in one edge resolve in favour of port A.
`timescale 1ns/100ps
`include "bram_params.svh"
module dual_port_bram (
    input  wire logic                                clk_i,
    input  wire logic                                srst_i,
    input  wire logic                                sleep_i,
    input  wire logic                                ecc_pipe_ce_i,
    input  wire logic                                a_en_i,
    input  wire logic            [`BRAM_WE_W-1:0]    a_we_i,
    input  wire logic            [`BRAM_ADDR_A_W-1:0] a_addr_i,
    input  wire logic            [`BRAM_DATA_W-1:0]  a_wdata_i,
    input  wire logic                                a_orst_i,
    input  wire logic                                a_regce_i,
    input  wire logic                                a_inj_sbit_i,
    input  wire logic                                a_inj_dbit_i,
    output logic                 [`BRAM_DATA_W-1:0]  a_rdata_o,
    output logic                                     a_sbit_err_o,
    output logic                                     a_dbit_err_o,
    output logic                 [`BRAM_ADDR_A_W-1:0] a_err_addr_o,
    input  wire logic                                b_en_i,
    input  wire logic            [`BRAM_WE_W-1:0]    b_we_i,
    input  wire logic            [`BRAM_ADDR_B_W-1:0] b_addr_i,
    input  wire logic            [`BRAM_DATA_W-1:0]  b_wdata_i,
    input  wire logic                                b_orst_i,
    input  wire logic                                b_regce_i,
    input  wire logic                                b_inj_sbit_i,
    input  wire logic                                b_inj_dbit_i,
    output logic                 [`BRAM_DATA_W-1:0]  b_rdata_o,
    output logic                                     b_sbit_err_o,
    output logic                                     b_dbit_err_o,
    output logic                 [`BRAM_ADDR_B_W-1:0] b_err_addr_o
);
    bram_pkg::code_t mem_ff [`BRAM_DEPTH_A];
    bram_pkg::code_t nxt_mem_ff [`BRAM_DEPTH_A];
    bram_pkg::code_t a_code;
    bram_pkg::code_t b_code;
    logic            a_act;
    logic            b_act;
    logic            a_wr;
    logic            b_wr;
    logic            a_rd;
    logic            b_rd;
    logic            a_rst;
    logic            b_rst;

    // Sleep blocks every access so the array and pipes stay frozen while powered down.
    assign a_act = a_en_i && !sleep_i;
    assign b_act = b_en_i && !sleep_i;
    // Byte writes are disabled in this build, so a single enable bit covers the word.
    assign a_wr  = a_act && (|a_we_i);
    assign b_wr  = b_act && (|b_we_i) && (`BRAM_TRUE_DUAL != 0);
    assign a_rd  = a_act && !(|a_we_i);
    assign b_rd  = b_act && !(|b_we_i);
    assign a_rst = a_act && a_orst_i;
    assign b_rst = b_act && b_orst_i;

    ecc_encoder u_enc_a (
        .data_i     (a_wdata_i),
        .inj_sbit_i (a_inj_sbit_i),
        .inj_dbit_i (a_inj_dbit_i),
        .code_o     (a_code)
    );

    ecc_encoder u_enc_b (
        .data_i     (b_wdata_i),
        .inj_sbit_i (b_inj_sbit_i),
        .inj_dbit_i (b_inj_dbit_i),
        .code_o     (b_code)
    );

    always_comb begin
        nxt_mem_ff = mem_ff;
        if (b_wr) begin
            nxt_mem_ff[b_addr_i] = b_code;
        end
        // Port A is applied last so it wins a same-address collision.
        if (a_wr) begin
            nxt_mem_ff[a_addr_i] = a_code;
        end
    end

    // One clock serves both ports; the integrator ties the port clocks together.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < `BRAM_DEPTH_A; i++) begin
                mem_ff[i] <= '0;
            end
        end else begin
            mem_ff <= nxt_mem_ff;
        end
    end

    read_pipe #(
        .AW (`BRAM_ADDR_A_W)
    ) u_pipe_a (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .rd_fire_i  (a_rd),
        .rst_fire_i (a_rst),
        .pipe_ce_i  (ecc_pipe_ce_i && !sleep_i),
        .regce_i    (a_regce_i && !sleep_i),
        .code_i     (mem_ff[a_addr_i]),
        .addr_i     (a_addr_i),
        .data_o     (a_rdata_o),
        .sbit_o     (a_sbit_err_o),
        .dbit_o     (a_dbit_err_o),
        .addr_o     (a_err_addr_o)
    );

    read_pipe #(
        .AW (`BRAM_ADDR_B_W)
    ) u_pipe_b (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .rd_fire_i  (b_rd),
        .rst_fire_i (b_rst),
        .pipe_ce_i  (ecc_pipe_ce_i && !sleep_i),
        .regce_i    (b_regce_i && !sleep_i),
        .code_i     (mem_ff[b_addr_i]),
        .addr_i     (b_addr_i),
        .data_o     (b_rdata_o),
        .sbit_o     (b_sbit_err_o),
        .dbit_o     (b_dbit_err_o),
        .addr_o     (b_err_addr_o)
    );
endmodule : dual_port_bram

// file: design/ecc_encoder.sv
// Purpose: SECDED encoder with optional error injection.
// Assumes: Hamming parity at power-of-two positions, overall parity at bit 0.
// Notes: Purely combinational; the caller registers the result into memory.
`timescale 1ns/100ps
`include "bram_params.svh"
module ecc_encoder (
    input  wire logic            [`BRAM_DATA_W-1:0] data_i,
    input  wire logic                               inj_sbit_i,
    input  wire logic                               inj_dbit_i,
    output logic                 [`BRAM_CODE_W-1:0] code_o
);
    always_comb begin
        int j;
        logic par;
        j = 0;
        par = 1'b0;
        code_o = '0;
        for (int p = 1; p < `BRAM_CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                code_o[p] = data_i[j];
                j++;
            end
        end
        for (int k = 0; k < `BRAM_PAR_N; k++) begin
            par = 1'b0;
            for (int p = 1; p < `BRAM_CODE_W; p++) begin
                if (((p >> k) & 1) != 0) begin
                    par = par ^ code_o[p];
                end
            end
            code_o[1 << k] = par;
        end
        code_o[`BRAM_OVERALL_BIT] = ^code_o[`BRAM_CODE_TOP:1];
        // Injection flips bits after encoding so the decoder sees a genuine fault.
        if (inj_sbit_i || inj_dbit_i) begin
            code_o[`BRAM_INJ_BIT0] = ~code_o[`BRAM_INJ_BIT0];
        end
        if (inj_dbit_i) begin
            code_o[`BRAM_INJ_BIT1] = ~code_o[`BRAM_INJ_BIT1];
        end
    end
endmodule : ecc_encoder

// file: design/read_pipe.sv
// Purpose: Read latch, ECC decode, ECC pipe register and output register of one port.
// Assumes: Caller gates fire strobes with port enable and sleep.
// Notes: Output reset clears every stage of this port but never the array.
`timescale 1ns/100ps
`include "bram_params.svh"
module read_pipe #(
    parameter int AW = 8
) (
    input  wire logic                               clk_i,
    input  wire logic                               srst_i,
    input  wire logic                               rd_fire_i,
    input  wire logic                               rst_fire_i,
    input  wire logic                               pipe_ce_i,
    input  wire logic                               regce_i,
    input  wire logic            [`BRAM_CODE_W-1:0] code_i,
    input  wire logic            [AW-1:0]           addr_i,
    output logic                 [`BRAM_DATA_W-1:0] data_o,
    output logic                                    sbit_o,
    output logic                                    dbit_o,
    output logic                 [AW-1:0]           addr_o
);
    logic [`BRAM_CODE_W-1:0] lat_code_ff, nxt_lat_code_ff;
    logic [AW-1:0]           lat_addr_ff, nxt_lat_addr_ff;
    logic [`BRAM_DATA_W-1:0] dec_data;
    logic                    dec_sbit;
    logic                    dec_dbit;
    logic [`BRAM_DATA_W-1:0] pipe_data_ff, nxt_pipe_data_ff;
    logic                    pipe_sbit_ff, nxt_pipe_sbit_ff;
    logic                    pipe_dbit_ff, nxt_pipe_dbit_ff;
    logic [AW-1:0]           pipe_addr_ff, nxt_pipe_addr_ff;
    logic [`BRAM_DATA_W-1:0] out_data_ff, nxt_out_data_ff;
    logic                    out_sbit_ff, nxt_out_sbit_ff;
    logic                    out_dbit_ff, nxt_out_dbit_ff;
    logic [AW-1:0]           out_addr_ff, nxt_out_addr_ff;

    always_comb begin
        logic [`BRAM_PAR_N-1:0]  syn;
        logic                    overall;
        logic [`BRAM_CODE_W-1:0] fixed;
        int j;
        syn = '0;
        j = 0;
        overall = ^lat_code_ff;
        fixed = lat_code_ff;
        dec_sbit = 1'b0;
        dec_dbit = 1'b0;
        dec_data = '0;
        for (int p = 1; p < `BRAM_CODE_W; p++) begin
            if (lat_code_ff[p]) begin
                syn = syn ^ p[`BRAM_PAR_N-1:0];
            end
        end
        if (overall) begin
            if (int'(syn) < `BRAM_CODE_W) begin
                fixed[syn] = ~fixed[syn];
                dec_sbit = 1'b1;
            end else begin
                dec_dbit = 1'b1;
            end
        end else if (syn != '0) begin
            fixed = lat_code_ff;
            dec_dbit = 1'b1;
        end
        for (int p = 1; p < `BRAM_CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                dec_data[j] = fixed[p];
                j++;
            end
        end
    end

    always_comb begin
        nxt_lat_code_ff  = lat_code_ff;
        nxt_lat_addr_ff  = lat_addr_ff;
        nxt_pipe_data_ff = pipe_data_ff;
        nxt_pipe_sbit_ff = pipe_sbit_ff;
        nxt_pipe_dbit_ff = pipe_dbit_ff;
        nxt_pipe_addr_ff = pipe_addr_ff;
        nxt_out_data_ff  = out_data_ff;
        nxt_out_sbit_ff  = out_sbit_ff;
        nxt_out_dbit_ff  = out_dbit_ff;
        nxt_out_addr_ff  = out_addr_ff;
        if (rst_fire_i) begin
            nxt_lat_code_ff  = '0;
            nxt_lat_addr_ff  = '0;
            nxt_pipe_data_ff = '0;
            nxt_pipe_sbit_ff = 1'b0;
            nxt_pipe_dbit_ff = 1'b0;
            nxt_pipe_addr_ff = '0;
            nxt_out_data_ff  = '0;
            nxt_out_sbit_ff  = 1'b0;
            nxt_out_dbit_ff  = 1'b0;
            nxt_out_addr_ff  = '0;
        end else begin
            if (rd_fire_i) begin
                nxt_lat_code_ff = code_i;
                nxt_lat_addr_ff = addr_i;
            end
            if (pipe_ce_i) begin
                nxt_pipe_data_ff = dec_data;
                nxt_pipe_sbit_ff = dec_sbit;
                nxt_pipe_dbit_ff = dec_dbit;
                nxt_pipe_addr_ff = lat_addr_ff;
            end
            if (regce_i) begin
                nxt_out_data_ff = pipe_data_ff;
                nxt_out_sbit_ff = pipe_sbit_ff;
                nxt_out_dbit_ff = pipe_dbit_ff;
                nxt_out_addr_ff = pipe_addr_ff;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lat_code_ff  <= '0;
            lat_addr_ff  <= '0;
            pipe_data_ff <= '0;
            pipe_sbit_ff <= 1'b0;
            pipe_dbit_ff <= 1'b0;
            pipe_addr_ff <= '0;
            out_data_ff  <= '0;
            out_sbit_ff  <= 1'b0;
            out_dbit_ff  <= 1'b0;
            out_addr_ff  <= '0;
        end else begin
            lat_code_ff  <= nxt_lat_code_ff;
            lat_addr_ff  <= nxt_lat_addr_ff;
            pipe_data_ff <= nxt_pipe_data_ff;
            pipe_sbit_ff <= nxt_pipe_sbit_ff;
            pipe_dbit_ff <= nxt_pipe_dbit_ff;
            pipe_addr_ff <= nxt_pipe_addr_ff;
            out_data_ff  <= nxt_out_data_ff;
            out_sbit_ff  <= nxt_out_sbit_ff;
            out_dbit_ff  <= nxt_out_dbit_ff;
            out_addr_ff  <= nxt_out_addr_ff;
        end
    end

    assign data_o = out_data_ff;
    assign sbit_o = out_sbit_ff;
    assign dbit_o = out_dbit_ff;
    assign addr_o = out_addr_ff;
endmodule : read_pipe

// file: verif/dual_port_bram_props.sv
// Purpose: Port-level checks of the dual-port block RAM.
// Assumes: One clock domain with synchronous reset srst_i.
// Notes: Output checks exclude cycles where the port's own output reset acts.
`timescale 1ns/100ps
`include "bram_params.svh"
module dual_port_bram_props (
    input  wire logic                         clk_i,
    input  wire logic                         srst_i,
    input  wire logic                         sleep_i,
    input  wire logic                         ecc_pipe_ce_i,
    input  wire logic                         a_en_i,
    input  wire logic [`BRAM_WE_W-1:0]        a_we_i,
    input  wire logic [`BRAM_ADDR_A_W-1:0]    a_addr_i,
    input  wire logic                         a_orst_i,
    input  wire logic                         a_regce_i,
    input  wire logic [`BRAM_DATA_W-1:0]      a_rdata_o,
    input  wire logic                         a_sbit_err_o,
    input  wire logic                         a_dbit_err_o,
    input  wire logic [`BRAM_ADDR_A_W-1:0]    a_err_addr_o,
    input  wire logic                         b_en_i,
    input  wire logic [`BRAM_WE_W-1:0]        b_we_i,
    input  wire logic [`BRAM_ADDR_B_W-1:0]    b_addr_i,
    input  wire logic                         b_orst_i,
    input  wire logic                         b_regce_i,
    input  wire logic [`BRAM_DATA_W-1:0]      b_rdata_o,
    input  wire logic                         b_sbit_err_o,
    input  wire logic                         b_dbit_err_o,
    input  wire logic [`BRAM_ADDR_B_W-1:0]    b_err_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_orst_clr_a: assert property (a_en_i && a_orst_i && !sleep_i |=> a_rdata_o == '0 && !a_sbit_err_o && !a_dbit_err_o)
        else $error("port A output reset did not clear");
    a_orst_clr_b: assert property (b_en_i && b_orst_i && !sleep_i |=> b_rdata_o == '0 && !b_sbit_err_o && !b_dbit_err_o)
        else $error("port B output reset did not clear");
    a_regce_hold_a: assert property (!a_regce_i && !(a_en_i && a_orst_i) |=> $stable(a_rdata_o))
        else $error("port A output moved without register enable");
    a_regce_hold_b: assert property (!b_regce_i && !(b_en_i && b_orst_i) |=> $stable(b_rdata_o))
        else $error("port B output moved without register enable");
    a_sleep_freeze: assert property (sleep_i |=> $stable(a_rdata_o) && $stable(b_rdata_o))
        else $error("output moved during sleep");
    a_flag_excl: assert property (a_dbit_err_o || b_dbit_err_o |-> !(a_sbit_err_o && a_dbit_err_o) && !(b_sbit_err_o && b_dbit_err_o))
        else $error("single and double error flags together");
    a_pipe_ce_a: assert property ((!ecc_pipe_ce_i && a_regce_i && !sleep_i && !(a_en_i && a_orst_i))
        ##1 !(a_en_i && a_orst_i) |=> $stable(a_rdata_o))
        else $error("ECC pipe advanced without its enable");
    a_err_addr_a: assert property ((a_en_i && !a_we_i[0] && !sleep_i && !a_orst_i) ##1 (ecc_pipe_ce_i && !sleep_i && !(a_en_i && a_orst_i))
        ##1 (a_regce_i && !sleep_i && !(a_en_i && a_orst_i)) |=> a_err_addr_o == $past(a_addr_i, 3))
        else $error("port A read address not aligned with data");
    a_err_addr_b: assert property ((b_en_i && !b_we_i[0] && !sleep_i && !b_orst_i) ##1 (ecc_pipe_ce_i && !sleep_i && !(b_en_i && b_orst_i))
        ##1 (b_regce_i && !sleep_i && !(b_en_i && b_orst_i)) |=> b_err_addr_o == $past(b_addr_i, 3))
        else $error("port B read address not aligned with data");
endmodule : dual_port_bram_props

bind dual_port_bram dual_port_bram_props dual_port_bram_props_i (.clk_i, .srst_i, .sleep_i, .ecc_pipe_ce_i,
    .a_en_i, .a_we_i, .a_addr_i, .a_orst_i, .a_regce_i, .a_rdata_o, .a_sbit_err_o, .a_dbit_err_o, .a_err_addr_o,
    .b_en_i, .b_we_i, .b_addr_i, .b_orst_i, .b_regce_i, .b_rdata_o, .b_sbit_err_o, .b_dbit_err_o, .b_err_addr_o);

// file: verif/dual_port_bram_tb_top.sv
// Purpose: Self-checking bench for the dual-port block RAM.
// Assumes: Both ports run on clk_i and are driven by port_user models.
// Notes: Read results are judged three edges after the request, the full pipeline depth.
`timescale 1ns/100ps
`include "bram_params.svh"
module dual_port_bram_tb_top;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic sleep_i = 1'b0;
    logic ecc_ce = 1'b1;
    logic a_regce = 1'b1;
    logic b_regce = 1'b1;
    logic a_en, a_orst, a_is, a_id, b_en, b_orst, b_is, b_id, a_sb, a_db, b_sb, b_db;
    logic [`BRAM_WE_W-1:0] a_we, b_we;
    bram_pkg::addr_a_t a_ad, a_ea, b_ad, b_ea;
    bram_pkg::data_t a_wd, a_rd, b_wd, b_rd;
    int fail_count = 0;
    int compares = 0;

    always #25 clk_i = ~clk_i;

    port_user pa (.clk_i(clk_i), .en_o(a_en), .we_o(a_we), .addr_o(a_ad), .wdata_o(a_wd), .orst_o(a_orst),
        .inj_s_o(a_is), .inj_d_o(a_id));
    port_user pb (.clk_i(clk_i), .en_o(b_en), .we_o(b_we), .addr_o(b_ad), .wdata_o(b_wd), .orst_o(b_orst),
        .inj_s_o(b_is), .inj_d_o(b_id));
    dual_port_bram dual_port_bram_i (.clk_i(clk_i), .srst_i(srst_i), .sleep_i(sleep_i), .ecc_pipe_ce_i(ecc_ce),
        .a_en_i(a_en), .a_we_i(a_we), .a_addr_i(a_ad), .a_wdata_i(a_wd), .a_orst_i(a_orst), .a_regce_i(a_regce),
        .a_inj_sbit_i(a_is), .a_inj_dbit_i(a_id), .a_rdata_o(a_rd), .a_sbit_err_o(a_sb), .a_dbit_err_o(a_db),
        .a_err_addr_o(a_ea), .b_en_i(b_en), .b_we_i(b_we), .b_addr_i(b_ad), .b_wdata_i(b_wd), .b_orst_i(b_orst),
        .b_regce_i(b_regce), .b_inj_sbit_i(b_is), .b_inj_dbit_i(b_id), .b_rdata_o(b_rd), .b_sbit_err_o(b_sb),
        .b_dbit_err_o(b_db), .b_err_addr_o(b_ea));

    task automatic cmp_d(input bram_pkg::data_t got, input bram_pkg::data_t exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t data %h expected %h", $time, got, exp);
        end
    endtask : cmp_d

    task automatic cmp_f(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : cmp_f

    task automatic cmp_a(input bram_pkg::addr_a_t got, input bram_pkg::addr_a_t exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t address %h expected %h", $time, got, exp);
        end
    endtask : cmp_a

    task automatic wr(input logic p, input bram_pkg::addr_a_t ad, input bram_pkg::data_t d, input logic is,
                      input logic id);
        if (p) pb.acc(1'b1, ad, d, 1'b0, is, id);
        else pa.acc(1'b1, ad, d, 1'b0, is, id);
    endtask : wr

    // The pipeline is latch, ECC stage and output register, so data shows after the third edge, two after acc returns.
    task automatic rd(input logic p, input bram_pkg::addr_a_t ad, input bram_pkg::data_t ex, input logic sb,
                      input logic db);
        if (p) pb.acc(1'b0, ad, '0, 1'b0, 1'b0, 1'b0);
        else pa.acc(1'b0, ad, '0, 1'b0, 1'b0, 1'b0);
        repeat (2) @(posedge clk_i);
        #1;
        cmp_d(p ? b_rd : a_rd, ex);
        cmp_f(p ? b_sb : a_sb, sb);
        cmp_f(p ? b_db : a_db, db);
        cmp_a(p ? b_ea : a_ea, ad);
    endtask : rd

    task automatic t_rw();
        wr(1'b0, 8'h10, 16'h1234, 1'b0, 1'b0);
        wr(1'b1, 8'h11, 16'habcd, 1'b0, 1'b0);
        rd(1'b1, 8'h10, 16'h1234, 1'b0, 1'b0);
        rd(1'b0, 8'h11, 16'habcd, 1'b0, 1'b0);
        $display("test t_rw done");
    endtask : t_rw

    task automatic t_ecc();
        wr(1'b0, 8'h20, 16'h5a5a, 1'b1, 1'b0);
        rd(1'b1, 8'h20, 16'h5a5a, 1'b1, 1'b0);
        wr(1'b1, 8'h21, 16'h0f0f, 1'b0, 1'b1);
        rd(1'b0, 8'h21, 16'h0f0f ^ 16'h0003, 1'b0, 1'b1);
        $display("test t_ecc done");
    endtask : t_ecc

    // After the read the idle port shows a write of all ones to 0xcf with enable low.
    task automatic t_en();
        rd(1'b0, 8'h30, 16'h0000, 1'b0, 1'b0);
        rd(1'b1, 8'hcf, 16'h0000, 1'b0, 1'b0);
        $display("test t_en done");
    endtask : t_en

    task automatic t_orst();
        rd(1'b0, 8'h10, 16'h1234, 1'b0, 1'b0);
        pa.acc(1'b0, 8'h10, '0, 1'b1, 1'b0, 1'b0);
        cmp_d(a_rd, '0);
        pb.acc(1'b0, 8'h10, '0, 1'b1, 1'b0, 1'b0);
        cmp_d(b_rd, '0);
        rd(1'b0, 8'h10, 16'h1234, 1'b0, 1'b0);
        $display("test t_orst done");
    endtask : t_orst

    task automatic t_regce();
        a_regce = 1'b0;
        pa.acc(1'b0, 8'h11, '0, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clk_i);
        #1;
        cmp_d(a_rd, 16'h1234);
        a_regce = 1'b1;
        @(posedge clk_i);
        #1;
        cmp_d(a_rd, 16'habcd);
        // Port B still shows the zero left by its output reset until its register enable returns.
        b_regce = 1'b0;
        pb.acc(1'b0, 8'h10, '0, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clk_i);
        #1;
        cmp_d(b_rd, 16'h0000);
        b_regce = 1'b1;
        @(posedge clk_i);
        #1;
        cmp_d(b_rd, 16'h1234);
        $display("test t_regce done");
    endtask : t_regce

    task automatic t_pipe();
        ecc_ce = 1'b0;
        pa.acc(1'b0, 8'h10, '0, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clk_i);
        #1;
        cmp_d(a_rd, 16'habcd);
        ecc_ce = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        cmp_d(a_rd, 16'h1234);
        $display("test t_pipe done");
    endtask : t_pipe

    task automatic t_sleep();
        sleep_i = 1'b1;
        wr(1'b1, 8'h10, 16'hdead, 1'b0, 1'b0);
        sleep_i = 1'b0;
        rd(1'b1, 8'h10, 16'h1234, 1'b0, 1'b0);
        $display("test t_sleep done");
    endtask : t_sleep

    task automatic stop_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (4) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        t_rw();
        t_ecc();
        t_en();
        t_orst();
        t_regce();
        t_pipe();
        t_sleep();
        stop_test();
    end

    // The scenarios need well under 200 cycles; this limit only catches a hang.
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
endmodule : dual_port_bram_tb_top

// file: verif/port_user.sv
// Purpose: Model of the user logic that drives one native port.
// Assumes: Requests are changed 1 ns after the rising edge and held for one edge.
// Notes: A released port drops enable and injection and inverts write enable, address, data and output reset, so stale inputs are never mistaken for requests.
`timescale 1ns/100ps
`include "bram_params.svh"
module port_user (
    input  wire logic                    clk_i,
    output logic                         en_o,
    output logic     [`BRAM_WE_W-1:0]    we_o,
    output bram_pkg::addr_a_t            addr_o,
    output bram_pkg::data_t              wdata_o,
    output logic                         orst_o,
    output logic                         inj_s_o,
    output logic                         inj_d_o
);
    initial begin
        en_o = 1'b0;
        we_o = '0;
        addr_o = '0;
        wdata_o = '0;
        orst_o = 1'b0;
        inj_s_o = 1'b0;
        inj_d_o = 1'b0;
    end

    task automatic acc(input logic we, input bram_pkg::addr_a_t a, input bram_pkg::data_t d,
                       input logic rs, input logic is, input logic id);
        @(posedge clk_i);
        #1;
        en_o = 1'b1;
        we_o = {`BRAM_WE_W{we}};
        addr_o = a;
        wdata_o = d;
        orst_o = rs;
        inj_s_o = is;
        inj_d_o = id;
        @(posedge clk_i);
        #1;
        en_o = 1'b0;
        we_o = ~we_o;
        addr_o = ~a;
        wdata_o = ~d;
        orst_o = ~rs;
        inj_s_o = 1'b0;
        inj_d_o = 1'b0;
    endtask : acc
endmodule : port_user
